/* rtl/csf_map.svh */
// Purpose: Offsets, field positions, reset values and BCD correction constants for the status flags block
// Assumes: 8-bit flags register in the internal register file
// Notes:   Included by the flags module and the testbench
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH
`define CSF_FLAGS_ADDR      8'hd5
`define CSF_FLAGS_RESET     8'h00
`define CSF_BIT_CARRY       7
`define CSF_BIT_ZERO        6
`define CSF_BIT_SIGN        5
`define CSF_BIT_OVFL        4
`define CSF_BIT_DEC         3
`define CSF_BIT_HALF        2
`define CSF_BIT_FIS         1
`define CSF_BIT_BANK        0
`define CSF_BCD_LO_FIX      8'h06
`define CSF_BCD_HI_FIX      8'h60
`define CSF_BCD_LO_LIMIT    4'h9
`define CSF_BCD_HI_LIMIT    8'h99
`endif

/* rtl/csf_pkg.sv */
// Purpose: Types shared by the status flags block and its users
// Assumes: One operation request per cycle from the sequencer
// Notes:   Operation codes are internal, not opcodes
package csf_pkg;
  typedef enum logic [4:0] {
    CSF_OP_NONE, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CMP,
    CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_TEST, CSF_OP_INC, CSF_OP_DEC,
    CSF_OP_RLC, CSF_OP_RRC, CSF_OP_RL, CSF_OP_RR, CSF_OP_SRA, CSF_OP_DA,
    CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF, CSF_OP_SB0, CSF_OP_SB1,
    CSF_OP_JPI, CSF_OP_SRP
  } csf_op_t;

  typedef enum logic [2:0] {
    CSF_AM_RR  = 3'h0,
    CSF_AM_RIR = 3'h1,
    CSF_AM_GG  = 3'h2,
    CSF_AM_GIG = 3'h3,
    CSF_AM_GIM = 3'h4,
    CSF_AM_ONE = 3'h5,
    CSF_AM_NA  = 3'h7
  } csf_mode_t;

  typedef struct packed {
    logic      valid;
    csf_op_t   op;
    csf_mode_t mode;
  } csf_dec_t;

  typedef struct packed {
    logic    valid;
    csf_op_t op;
    logic [7:0] dst;
    logic [7:0] src;
  } csf_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } csf_wr_t;

  typedef enum logic [2:0] {
    CSF_ST_RUN  = 3'b001,
    CSF_ST_FAST = 3'b010,
    CSF_ST_RET  = 3'b100
  } csf_state_t;
endpackage

/* rtl/csf_flags.sv */
// Purpose: Status flags register, flag update logic and opcode decode fragment
// Assumes: Sequencer presents one operation per cycle; results seen next cycle
// Notes:   Result and flags both registered; flags visible to the next operation
//
// Contract
// [RULE_01] Carry set on carry out of or borrow into bit 7.
// [RULE_02] Rotate and shift load carry with the bit shifted out.
// [RULE_03] Set, clear and invert carry operations touch only carry.
// [RULE_04] Zero flag set when the result is zero.
// [RULE_05] Sign flag copies result bit 7.
// [RULE_06] Overflow set when signed result leaves -128 to +127.
// [RULE_07] Logic operations clear overflow.
// [RULE_08] Decimal flag records add versus subtract; never a jump condition.
// [RULE_09] Half-carry on add carry out of bit 3 or subtract borrow from 4.
// [RULE_10] Decimal adjust uses half, carry and decimal flags to fix BCD.
// [RULE_11] Fast status bit set on fast interrupt, cleared by its return.
// [RULE_12] Fast status blocks interrupts; return then uses fast sequence.
// [RULE_13] Bank flag selects bank 0 or 1 for set 1 area.
// [RULE_14] Bank zero op clears bank flag, bank one op sets it.
// [RULE_15] Flags writable as a register by non flag-updating instructions.
// [RULE_16] Flag update and register write collision has no guaranteed result.
// [RULE_17] AND updates zero, sign, overflow and leaves carry.
// [RULE_18] Upper nibbles 0-4, lower 2-6 decode to add..OR in five forms.
// [RULE_19] Lower nibbles 0-1 decode to dec, rotate, inc, adjust, jump, pointer.
// [RULE_20] Pair operands even 0-254 or 0-14; working registers 0-15.
// [RULE_21] Relative target is next address plus signed 8-bit offset.
// [RULE_22] Fast return swaps pointer and counter, restores flags, clears bit.
// [RULE_23] Flag updates land at instruction end, seen by the next.
`timescale 1ns/1ps
`include "csf_map.svh"

module csf_flags #(
  parameter int ADDR_W = 16
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire csf_pkg::csf_req_t  req_in,
  input  wire csf_pkg::csf_wr_t   reg_wr_in,
  input  wire logic [7:0]         opcode_in,
  input  wire logic               fast_irq_begin_in,
  input  wire logic               interrupt_return_op_in,
  input  wire logic [ADDR_W-1:0]  pc_in,
  input  wire logic [ADDR_W-1:0]  next_pc_in,
  input  wire logic [7:0]         rel_offset_in,
  input  wire logic [7:0]         pair_reg_in,
  input  wire logic [3:0]         work_reg_in,
  input  wire logic [ADDR_W-1:0]  fast_service_pointer_in,
  output logic [7:0]              cpu_status_flags_out,
  output logic [7:0]              result_out,
  output csf_pkg::csf_dec_t       dec_out,
  output logic                    irq_block_out,
  output logic                    fast_return_out,
  output logic                    bank_sel_out,
  output logic [ADDR_W-1:0]       branch_target_out,
  output logic [7:0]              pair_addr_out,
  output logic [7:0]              work_addr_out,
  output logic [ADDR_W-1:0]       swap_pc_out,
  output logic [ADDR_W-1:0]       swap_ptr_out
);
  import csf_pkg::*;

  initial begin
    if (ADDR_W < 8) $error("ADDR_W must be at least 8");
  end

  logic       rst_m_q;
  logic       rst_s_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] shadow_q;
  logic [7:0] res_d;
  csf_state_t st_q;

  // Reset release through two stages
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  function automatic csf_dec_t decode(input logic [7:0] opc);
    csf_dec_t d;
    d = '{valid: 1'b0, op: CSF_OP_NONE, mode: CSF_AM_NA};
    // [RULE_18] Arithmetic and OR forms
    if (opc[7:4] <= 4'h4 && opc[3:0] >= 4'h2 && opc[3:0] <= 4'h6) begin
      d.valid = 1'b1;
      d.mode  = csf_mode_t'(opc[2:0] - 3'h2);
      case (opc[7:4])
        4'h0: d.op = CSF_OP_ADD;
        4'h1: d.op = CSF_OP_ADC;
        4'h2: d.op = CSF_OP_SUB;
        4'h3: d.op = CSF_OP_SBC;
        default: d.op = CSF_OP_OR;
      endcase
    // [RULE_19] Single operand forms
    end else if (opc[7:4] <= 4'h4 && opc[3:1] == 3'h0) begin
      d.valid = 1'b1;
      d.mode  = opc[0] ? CSF_AM_RIR : CSF_AM_ONE;
      case (opc[7:4])
        4'h0: d.op = CSF_OP_DEC;
        4'h1: d.op = CSF_OP_RLC;
        4'h2: d.op = CSF_OP_INC;
        4'h3: d.op = opc[0] ? CSF_OP_SRP : CSF_OP_JPI;
        default: d.op = CSF_OP_DA;
      endcase
    end
    return d;
  endfunction

  // Flag computation, one path per operation class
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic       cin;
    logic       sub;
    logic [7:0] adj;
    logic       arith;
    sum     = 9'h000;
    nib     = 5'h00;
    adj     = 8'h00;
    cin     = 1'b0;
    sub     = 1'b0;
    arith   = 1'b0;
    flags_d = flags_q;
    res_d   = result_out;
    case (req_in.op)
      CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CMP: begin
        sub   = (req_in.op == CSF_OP_SUB) || (req_in.op == CSF_OP_SBC) ||
                (req_in.op == CSF_OP_CMP);
        cin   = ((req_in.op == CSF_OP_ADC) || (req_in.op == CSF_OP_SBC)) &&
                flags_q[`CSF_BIT_CARRY];
        arith = 1'b1;
        if (sub) begin
          sum = {1'b0, req_in.dst} - {1'b0, req_in.src} - {8'h00, cin};
          nib = {1'b0, req_in.dst[3:0]} - {1'b0, req_in.src[3:0]} - {4'h0, cin};
        end else begin
          sum = {1'b0, req_in.dst} + {1'b0, req_in.src} + {8'h00, cin};
          nib = {1'b0, req_in.dst[3:0]} + {1'b0, req_in.src[3:0]} + {4'h0, cin};
        end
        // [RULE_01] Carry or borrow at bit 7
        flags_d[`CSF_BIT_CARRY] = sum[8];
        // [RULE_06] Signed range overflow
        flags_d[`CSF_BIT_OVFL] = sub ?
          ((req_in.dst[7] != req_in.src[7]) && (sum[7] != req_in.dst[7])) :
          ((req_in.dst[7] == req_in.src[7]) && (sum[7] != req_in.dst[7]));
        // [RULE_08] Record add versus subtract
        flags_d[`CSF_BIT_DEC] = sub;
        // [RULE_09] Nibble carry or borrow
        flags_d[`CSF_BIT_HALF] = nib[4];
        if (req_in.op != CSF_OP_CMP) res_d = sum[7:0];
      end
      CSF_OP_INC, CSF_OP_DEC: begin
        sum = (req_in.op == CSF_OP_INC) ? {1'b0, req_in.dst} + 9'h001 :
                                          {1'b0, req_in.dst} - 9'h001;
        arith = 1'b1;
        // [RULE_06] Overflow at the signed limits
        flags_d[`CSF_BIT_OVFL] = (req_in.op == CSF_OP_INC) ? (req_in.dst == 8'h7f) :
                                                           (req_in.dst == 8'h80);
        res_d = sum[7:0];
      end
      CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_TEST: begin
        case (req_in.op)
          CSF_OP_AND:  sum = {1'b0, req_in.dst & req_in.src};
          CSF_OP_OR:   sum = {1'b0, req_in.dst | req_in.src};
          CSF_OP_XOR:  sum = {1'b0, req_in.dst ^ req_in.src};
          default:     sum = {1'b0, req_in.dst & req_in.src};
        endcase
        arith = 1'b1;
        // [RULE_07] Logic clears overflow
        // [RULE_17] Carry kept for logic ops
        flags_d[`CSF_BIT_OVFL] = 1'b0;
        if (req_in.op != CSF_OP_TEST) res_d = sum[7:0];
      end
      CSF_OP_RLC, CSF_OP_RRC, CSF_OP_RL, CSF_OP_RR, CSF_OP_SRA: begin
        case (req_in.op)
          CSF_OP_RLC: sum = {req_in.dst, flags_q[`CSF_BIT_CARRY]};
          CSF_OP_RL:  sum = {req_in.dst, req_in.dst[7]};
          CSF_OP_RRC: sum = {req_in.dst[0], flags_q[`CSF_BIT_CARRY], req_in.dst[7:1]};
          CSF_OP_RR:  sum = {req_in.dst[0], req_in.dst[0], req_in.dst[7:1]};
          default:    sum = {req_in.dst[0], req_in.dst[7], req_in.dst[7:1]};
        endcase
        arith = 1'b1;
        // [RULE_02] Bit shifted out into carry
        flags_d[`CSF_BIT_CARRY] = sum[8];
        flags_d[`CSF_BIT_OVFL]  = sum[7] ^ req_in.dst[7];
        res_d = sum[7:0];
      end
      CSF_OP_DA: begin
        // [RULE_10] BCD correction from C, H, D
        if (flags_q[`CSF_BIT_HALF] ||
            (!flags_q[`CSF_BIT_DEC] && req_in.dst[3:0] > `CSF_BCD_LO_LIMIT))
          adj = adj | `CSF_BCD_LO_FIX;
        if (flags_q[`CSF_BIT_CARRY] ||
            (!flags_q[`CSF_BIT_DEC] && req_in.dst > `CSF_BCD_HI_LIMIT))
          adj = adj | `CSF_BCD_HI_FIX;
        sum = flags_q[`CSF_BIT_DEC] ? {1'b0, req_in.dst - adj} :
                                      {1'b0, req_in.dst + adj};
        arith = 1'b1;
        flags_d[`CSF_BIT_CARRY] = adj[6];
        res_d = sum[7:0];
      end
      // [RULE_03] Carry-only operations
      CSF_OP_SCF: flags_d[`CSF_BIT_CARRY] = 1'b1;
      CSF_OP_RCF: flags_d[`CSF_BIT_CARRY] = 1'b0;
      CSF_OP_CCF: flags_d[`CSF_BIT_CARRY] = ~flags_q[`CSF_BIT_CARRY];
      // [RULE_14] Bank select operations
      CSF_OP_SB0: flags_d[`CSF_BIT_BANK] = 1'b0;
      CSF_OP_SB1: flags_d[`CSF_BIT_BANK] = 1'b1;
      default: ;
    endcase
    if (arith) begin
      // [RULE_04] Zero detect
      flags_d[`CSF_BIT_ZERO] = (sum[7:0] == 8'h00);
      // [RULE_05] Sign from MSB
      flags_d[`CSF_BIT_SIGN] = sum[7];
    end
    if (!req_in.valid) begin
      flags_d = flags_q;
      res_d   = result_out;
    end
  end

  // Flags register; later assignments win over earlier ones
  always_ff @(posedge clk_sys_in or negedge rst_s_q) begin
    if (!rst_s_q) begin
      flags_q  <= `CSF_FLAGS_RESET;
      shadow_q <= `CSF_FLAGS_RESET;
      st_q     <= CSF_ST_RUN;
    end else begin
      // [RULE_23] Flags land at instruction end
      flags_q <= flags_d;
      // [RULE_15] Plain register write
      // [RULE_16] Write wins a collision; not guaranteed
      if (reg_wr_in.valid && reg_wr_in.addr == `CSF_FLAGS_ADDR)
        flags_q <= reg_wr_in.data;
      case (st_q)
        CSF_ST_RUN: begin
          // [RULE_11] Enter fast service
          if (fast_irq_begin_in && !flags_q[`CSF_BIT_FIS]) begin
            shadow_q <= flags_q;
            flags_q[`CSF_BIT_FIS] <= 1'b1;
            st_q <= CSF_ST_FAST;
          end
        end
        CSF_ST_FAST: begin
          // [RULE_12] Return takes fast path
          if (interrupt_return_op_in && flags_q[`CSF_BIT_FIS]) begin
            // [RULE_22] Restore shadow and clear bit
            flags_q <= {shadow_q[7:2], 1'b0, shadow_q[0]};
            st_q    <= CSF_ST_RET;
          end
        end
        CSF_ST_RET: st_q <= CSF_ST_RUN;
        default:    st_q <= CSF_ST_RUN;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys_in or negedge rst_s_q) begin
    if (!rst_s_q) begin
      result_out        <= 8'h00;
      dec_out           <= '{valid: 1'b0, op: CSF_OP_NONE, mode: CSF_AM_NA};
      fast_return_out   <= 1'b0;
      branch_target_out <= '0;
      pair_addr_out     <= 8'h00;
      work_addr_out     <= 8'h00;
      swap_pc_out       <= '0;
      swap_ptr_out      <= '0;
    end else begin
      result_out <= res_d;
      dec_out    <= decode(opcode_in);
      fast_return_out <= (st_q == CSF_ST_FAST) && interrupt_return_op_in &&
                         flags_q[`CSF_BIT_FIS];
      // [RULE_21] Next address plus signed offset
      branch_target_out <= next_pc_in + {{(ADDR_W-8){rel_offset_in[7]}}, rel_offset_in};
      // [RULE_20] Even pairs, 16 working registers
      pair_addr_out <= {pair_reg_in[7:1], 1'b0};
      work_addr_out <= {4'h0, work_reg_in};
      // [RULE_22] Counter and pointer swap
      if ((fast_irq_begin_in && st_q == CSF_ST_RUN && !flags_q[`CSF_BIT_FIS]) ||
          (st_q == CSF_ST_FAST && interrupt_return_op_in && flags_q[`CSF_BIT_FIS])) begin
        swap_pc_out  <= fast_service_pointer_in;
        swap_ptr_out <= pc_in;
      end
    end
  end

  // Mirrors of flags; the decimal flag is never routed to conditions
  always_ff @(posedge clk_sys_in or negedge rst_s_q) begin
    if (!rst_s_q) begin
      cpu_status_flags_out <= `CSF_FLAGS_RESET;
      irq_block_out        <= 1'b0;
      bank_sel_out         <= 1'b0;
    end else begin
      cpu_status_flags_out <= flags_d;
      // [RULE_12] Block all interrupts
      irq_block_out <= flags_d[`CSF_BIT_FIS];
      // [RULE_13] Bank select output
      bank_sel_out  <= flags_d[`CSF_BIT_BANK];
    end
  end
endmodule

/* dv/csf_flags_chk.sv */
// Purpose: Port assertions for the status flags block
// Assumes: One clock, async active-low reset
// Notes:   Waits three edges after reset for the synced copy
`timescale 1ns/1ps
module csf_flags_chk
  import csf_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_n_in,
  input wire csf_pkg::csf_req_t req_in,
  input wire csf_pkg::csf_wr_t  reg_wr_in,
  input wire logic [7:0]        opcode_in,
  input wire logic              fast_irq_begin_in,
  input wire logic              interrupt_return_op_in,
  input wire logic [ADDR_W-1:0] next_pc_in,
  input wire logic [7:0]        rel_offset_in,
  input wire logic [7:0]        pair_reg_in,
  input wire logic [3:0]        work_reg_in,
  input wire logic [7:0]        cpu_status_flags_out,
  input wire logic [7:0]        result_out,
  input wire csf_pkg::csf_dec_t dec_out,
  input wire logic              irq_block_out,
  input wire logic              fast_return_out,
  input wire logic [ADDR_W-1:0] branch_target_out,
  input wire logic [7:0]        pair_addr_out,
  input wire logic [7:0]        work_addr_out
);
  localparam csf_op_t LO_OPS [5] = '{CSF_OP_DEC, CSF_OP_RLC, CSF_OP_INC, CSF_OP_JPI, CSF_OP_DA};
  localparam csf_op_t HI_OPS [5] = '{CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_OR};
  logic [1:0] live_q;
  logic       side_q;
  logic       live;
  logic       calm;
  csf_op_t    exp_op;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live_q <= 2'h0;
      side_q <= 1'b1;
    end else begin
      live_q <= live ? live_q : live_q + 2'h1;
      side_q <= reg_wr_in.valid | fast_irq_begin_in | interrupt_return_op_in;
    end
  end
  assign live = (live_q == 2'h3);
  // Side events reach the flags output a cycle late
  assign calm = live & req_in.valid & ~side_q & ~reg_wr_in.valid & ~fast_irq_begin_in
              & ~interrupt_return_op_in;
  always_comb begin
    exp_op = (opcode_in[3:1] == 3'h0) ? LO_OPS[opcode_in[6:4]] : HI_OPS[opcode_in[6:4]];
    if (opcode_in == 8'h31) begin
      exp_op = CSF_OP_SRP;
    end
  end
  a_carry_set: assert property (calm && req_in.op == CSF_OP_SCF |=> cpu_status_flags_out[7])
    else $error("carry not set");
  a_carry_invert: assert property (calm && req_in.op == CSF_OP_CCF
    |=> cpu_status_flags_out == ($past(cpu_status_flags_out) ^ 8'h80)) else $error("carry invert");
  a_zero_sign: assert property (calm && req_in.op inside {CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB,
    CSF_OP_SBC, CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_RLC}
    |=> cpu_status_flags_out[6:5] == {result_out == 8'h00, result_out[7]}) else $error("zero sign");
  a_logic_flags: assert property (calm && req_in.op inside {CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR}
    |=> !cpu_status_flags_out[4] && cpu_status_flags_out[7] == $past(cpu_status_flags_out[7]))
    else $error("logic flags");
  a_bank_select: assert property (calm && req_in.op inside {CSF_OP_SB0, CSF_OP_SB1}
    |=> cpu_status_flags_out[0] == ($past(req_in.op) == CSF_OP_SB1)) else $error("bank flag");
  a_fast_block: assert property (live && fast_irq_begin_in && !irq_block_out && !side_q
    && !interrupt_return_op_in && !reg_wr_in.valid |-> ##2 irq_block_out) else $error("no block");
  a_fast_return: assert property (live && interrupt_return_op_in && irq_block_out && !side_q
    && !fast_irq_begin_in && !$past(interrupt_return_op_in, 2) |=> fast_return_out)
    else $error("no fast return");
  a_branch_calc: assert property (live |=> branch_target_out == $past(next_pc_in)
    + {{(ADDR_W-8){$past(rel_offset_in[7])}}, $past(rel_offset_in)}) else $error("branch target");
  a_reg_numbers: assert property (live |=> pair_addr_out == {$past(pair_reg_in[7:1]), 1'b0}
    && work_addr_out == {4'h0, $past(work_reg_in)}) else $error("register numbers");
  // Lower nibble 7 lies outside the decoded fragment and reads as not valid
  a_decode_op: assert property (live && opcode_in[7:4] <= 4'h4 && !opcode_in[3]
    && opcode_in[2:0] != 3'h7
    |=> dec_out.valid && dec_out.op == $past(exp_op)) else $error("decode op");
  a_decode_form: assert property (live && opcode_in[7:4] <= 4'h4 && opcode_in[3:0] inside {[2:6]}
    |=> dec_out.mode == $past(opcode_in[2:0]) - 3'h2) else $error("decode form");
endmodule
bind csf_flags csf_flags_chk #(.ADDR_W(ADDR_W)) i_chk (.clk_sys_in, .rst_n_in, .req_in,
  .reg_wr_in, .opcode_in, .fast_irq_begin_in, .interrupt_return_op_in, .next_pc_in,
  .rel_offset_in, .pair_reg_in, .work_reg_in, .cpu_status_flags_out, .result_out, .dec_out,
  .irq_block_out, .fast_return_out, .branch_target_out, .pair_addr_out, .work_addr_out);

/* dv/csf_seq_model.sv */
// Purpose: Sequencer stand-in that issues flag operations
// Assumes: Caller waits one edge per call
// Notes:   Released dst, src, addr and data fields flip so stale data never passes; op is held
`timescale 1ns/1ps
module csf_seq_model
  import csf_pkg::*;
(
  input  wire logic        clk_sys_in,
  output csf_pkg::csf_req_t req_out,
  output csf_pkg::csf_wr_t  reg_wr_out,
  output logic              fast_irq_begin_out,
  output logic              interrupt_return_op_out
);
  initial begin
    req_out = '0;
    reg_wr_out = '0;
    fast_irq_begin_out = 1'b0;
    interrupt_return_op_out = 1'b0;
  end
  task automatic drive(input csf_req_t r, input csf_wr_t w, input logic irq, input logic ret);
    @(posedge clk_sys_in);
    if (!r.valid) begin
      r = '{1'b0, req_out.op, ~req_out.dst, ~req_out.src};
    end
    if (!w.valid) begin
      w = '{1'b0, ~reg_wr_out.addr, ~reg_wr_out.data};
    end
    req_out <= r;
    reg_wr_out <= w;
    fast_irq_begin_out <= irq;
    interrupt_return_op_out <= ret;
  endtask
endmodule

/* dv/cpu_status_flags_and_opcode_decode_tb.sv */
// Purpose: Self-checking bench for the status flags block
// Assumes: Model drives one operation per edge
// Notes:   Expected flags kept in a software copy
`timescale 1ns/1ps
`include "csf_map.svh"
module cpu_status_flags_and_opcode_decode_tb;
  import csf_pkg::*;
  localparam int AW = 16;
  localparam csf_op_t OPS [13] = '{CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_AND,
    CSF_OP_OR, CSF_OP_XOR, CSF_OP_RLC, CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF, CSF_OP_SB0, CSF_OP_SB1};
  logic          clk_sys_in = 1'b0;
  logic          rst_n_in = 1'b0;
  csf_req_t      req;
  csf_wr_t       wr;
  logic          irq;
  logic          ret;
  logic [7:0]    opc = 8'h00;
  logic [7:0]    off = 8'h00;
  logic [7:0]    pair = 8'h00;
  logic [3:0]    wreg = 4'h0;
  logic [AW-1:0] pc = '0;
  logic [AW-1:0] npc = '0;
  logic [AW-1:0] fsp = '0;
  logic [7:0]    flags;
  logic [7:0]    res;
  logic          blk;
  logic [7:0]    exp_f = 8'h00;
  logic [7:0]    shadow;
  logic [16:0]   q [$];
  int            errors = 0;
  int            checks = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    opc <= {1'b0, 3'($urandom_range(4)), 4'($urandom_range(7))};
    off <= 8'($urandom);
    pair <= 8'($urandom);
    wreg <= 4'($urandom);
    pc <= AW'($urandom);
    npc <= AW'($urandom);
    fsp <= AW'($urandom);
  end

  csf_seq_model i_seq (.clk_sys_in(clk_sys_in), .req_out(req), .reg_wr_out(wr),
    .fast_irq_begin_out(irq), .interrupt_return_op_out(ret));

  csf_flags #(.ADDR_W(AW)) i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
    .reg_wr_in(wr), .opcode_in(opc), .fast_irq_begin_in(irq), .interrupt_return_op_in(ret),
    .pc_in(pc), .next_pc_in(npc), .rel_offset_in(off), .pair_reg_in(pair), .work_reg_in(wreg),
    .fast_service_pointer_in(fsp), .cpu_status_flags_out(flags), .result_out(res), .dec_out(),
    .irq_block_out(blk), .fast_return_out(), .bank_sel_out(), .branch_target_out(),
    .pair_addr_out(), .work_addr_out(), .swap_pc_out(), .swap_ptr_out());

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [16:0] calc(csf_op_t o, logic [7:0] a, logic [7:0] b, logic [7:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic       c;
    logic       sub;
    logic       alu;
    sub = o inside {CSF_OP_SUB, CSF_OP_SBC};
    c = (o inside {CSF_OP_ADC, CSF_OP_SBC}) ? f[7] : 1'b0;
    s = sub ? {1'b0, a} - b - c : {1'b0, a} + b + c;
    h = sub ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
    alu = o inside {CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_AND, CSF_OP_OR,
      CSF_OP_XOR, CSF_OP_RLC};
    if (o inside {CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC}) begin
      f[7:2] = {s[8], 1'b0, 1'b0, (a[7] ^ b[7] ^ ~sub) & (s[7] ^ a[7]), sub, h[4]};
    end
    case (o)
      CSF_OP_AND: s[7:0] = a & b;
      CSF_OP_OR:  s[7:0] = a | b;
      CSF_OP_XOR: s[7:0] = a ^ b;
      CSF_OP_RLC: s = {a, f[7]};
      CSF_OP_SCF: f[7] = 1'b1;
      CSF_OP_RCF: f[7] = 1'b0;
      CSF_OP_CCF: f[7] = ~f[7];
      CSF_OP_SB0: f[0] = 1'b0;
      CSF_OP_SB1: f[0] = 1'b1;
      default: ;
    endcase
    if (o inside {CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR}) begin
      f[4] = 1'b0;
    end
    if (o == CSF_OP_RLC) begin
      f[7] = s[8];
      f[4] = a[7] ^ s[7];
    end
    if (alu) begin
      f[6:5] = {s[7:0] == 8'h00, s[7]};
    end
    return {alu, s[7:0], f};
  endfunction

  task automatic op(input csf_op_t o, input logic [7:0] a, input logic [7:0] b);
    logic [16:0] e;
    e = calc(o, a, b, exp_f);
    exp_f = e[7:0];
    q.push_back(e);
    i_seq.drive('{1'b1, o, a, b}, '0, 1'b0, 1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) i_seq.drive('0, '0, 1'b0, 1'b0);
  endtask

  // Results land at the taking edge; look half a cycle later
  always @(posedge clk_sys_in) begin
    if (rst_n_in && req.valid) begin
      @(negedge clk_sys_in);
      if (q.size() > 0) begin
        chk("flags", q[0][7:0], flags);
        if (q[0][16]) begin
          chk("result", q[0][15:8], res);
        end
        void'(q.pop_front());
      end
    end
  end

  task automatic give_verdict;
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(25ns * 4000);
    errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h36f342ae));
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    idle(3);
    @(negedge clk_sys_in);
    chk("reset flags", `CSF_FLAGS_RESET, flags);
    op(CSF_OP_ADD, 8'h0f, 8'h01);
    op(CSF_OP_ADD, 8'h7f, 8'h01);
    op(CSF_OP_ADD, 8'hff, 8'h01);
    op(CSF_OP_SUB, 8'h80, 8'h01);
    op(CSF_OP_SUB, 8'h10, 8'h01);
    op(CSF_OP_SBC, 8'h00, 8'h00);
    op(CSF_OP_RLC, 8'h80, 8'h00);
    op(CSF_OP_AND, 8'hf0, 8'h0f);
    repeat (80) begin
      op(OPS[$urandom_range(12)], 8'($urandom), 8'($urandom));
      idle($urandom_range(1));
    end
    exp_f = 8'($urandom) & 8'hfd;
    i_seq.drive('0, '{1'b1, `CSF_FLAGS_ADDR, exp_f}, 1'b0, 1'b0);
    idle(1);
    op(CSF_OP_CCF, 8'h00, 8'h00);
    shadow = exp_f;
    exp_f[1] = 1'b1;
    i_seq.drive('0, '0, 1'b1, 1'b0);
    idle(2);
    // Output settles after the launching edge
    @(negedge clk_sys_in);
    chk("irq block", 8'h01, {7'h00, blk});
    i_seq.drive('0, '0, 1'b1, 1'b0);
    idle(1);
    op(CSF_OP_RCF, 8'h00, 8'h00);
    op(CSF_OP_SB1, 8'h00, 8'h00);
    i_seq.drive('0, '0, 1'b0, 1'b1);
    exp_f = shadow & 8'hfd;
    idle(2);
    op(CSF_OP_SCF, 8'h00, 8'h00);
    idle(3);
    give_verdict();
  end
endmodule
